// [hw/bior_pkg.sv]
// constants for the banked host register window
// What this block does
// - sixteen host byte locations, registers grouped in banks
// - word 0xe-0xf selects bank in every bank
// - access is 8, 16 or 32 bits wide
// - only enabled byte lanes read or written
// - full 32-bit reads and writes accepted
// - station address low/mid/high at 0x0/0x2/0x4
// - host port is isa-like asynchronous strobe bus
// - start-up bit selects 16-bit or 8-bit width
// - eeprom words 0-6 loaded after reset release
package bior_pkg;
	// byte offsets inside a bank
	localparam logic [3:0] off_word0       = 4'h0;
	localparam logic [3:0] off_word2       = 4'h2;
	localparam logic [3:0] off_word4       = 4'h4;
	localparam logic [3:0] off_word6       = 4'h6;
	localparam logic [3:0] off_word8       = 4'h8;
	localparam logic [3:0] off_bank_select = 4'he;
	// bank numbers
	localparam logic [15:0] bank_host_cfg = 16'h0000;
	localparam logic [15:0] bank_station  = 16'h0002;
	localparam logic [15:0] bank_internal = 16'h0003;
	// reset values
	localparam logic [15:0] rst_word      = 16'h0000;
	localparam logic        rst_bus_16bit = 1'b1;
	// eeprom image layout
	localparam logic [2:0] ee_base_word   = 3'h0;
	localparam logic [2:0] ee_mac_lo_word = 3'h1;
	localparam logic [2:0] ee_mac_mi_word = 3'h2;
	localparam logic [2:0] ee_mac_hi_word = 3'h3;
	localparam logic [2:0] ee_cfg_word    = 3'h6;
	localparam int         ee_width_bit   = 0;
	// loader sequencer
	typedef enum logic [1:0] {
		bior_ld_start = 2'b00,
		bior_ld_req   = 2'b01,
		bior_ld_wait  = 2'b11,
		bior_ld_done  = 2'b10
	} bior_ld_state_t;
endpackage

// [hw/bior_load_if.sv]
// carrier from the eeprom loader to the register bank
`timescale 1ns/1ps
`default_nettype none
interface bior_load_if;
	logic        valid;
	logic [2:0]  index;
	logic [15:0] data;
	logic        busy;
	modport loader (output valid, output index, output data, output busy);
	modport bank   (input valid, input index, input data, input busy);
endinterface
`default_nettype wire

// [hw/bior_eeprom_load.sv]
// start-up loader for eeprom words 0 to 6
`timescale 1ns/1ps
`default_nettype none
module bior_eeprom_load (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          reset_n,
	// strap
	input  wire logic          eeprom_load_enable_pin,
	// eeprom word reader
	output logic               ee_req,
	output logic [2:0]         ee_word,
	input  wire logic          ee_ack,
	input  wire logic [15:0]   ee_data,
	// to the register bank
	bior_load_if.loader        ld
);
	import bior_pkg::*;

	typedef struct packed {
		bior_ld_state_t st;
		logic           req;
		logic [2:0]     word;
		logic           valid;
		logic [15:0]    data;
	} bior_ld_t;

	bior_ld_t s;
	bior_ld_t next_s;

	always_comb begin
		next_s = s;
		next_s.valid = 1'b0;
		unique case (s.st)
			// strap sampled on first clock after release, never under reset
			bior_ld_start: begin
				next_s.word = ee_base_word;
				if (eeprom_load_enable_pin) begin
					next_s.st  = bior_ld_req;
					next_s.req = 1'b1;
				end else begin
					next_s.st = bior_ld_done;
				end
			end
			bior_ld_req: begin
				next_s.st = bior_ld_wait;
			end
			bior_ld_wait: begin
				if (ee_ack) begin
					next_s.valid = 1'b1;
					next_s.data  = ee_data;
					if (s.word == ee_cfg_word) begin
						next_s.req = 1'b0;
						next_s.st  = bior_ld_done;
					end else begin
						next_s.word = s.word + 3'h1;
						next_s.st   = bior_ld_req;
					end
				end
			end
			bior_ld_done: begin
				next_s.req = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '{st: bior_ld_start, req: 1'b0, word: 3'h0, valid: 1'b0, data: 16'h0000};
		end else begin
			s <= next_s;
		end
	end

	assign ee_req   = s.req;
	assign ee_word  = s.word;
	assign ld.valid = s.valid;
	// index lags one cycle behind word, so report the word just captured
	assign ld.index = (s.st == bior_ld_done) ? ee_cfg_word : s.word - 3'h1;
	assign ld.data  = s.data;
	assign ld.busy  = (s.st != bior_ld_done);
endmodule
`default_nettype wire

// [hw/bior_top.sv]
// banked sixteen-byte host register window
`timescale 1ns/1ps
`default_nettype none
module bior_top (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          reset_n,
	// host strobe bus
	input  wire logic [3:0]    host_addr,
	input  wire logic [3:0]    byte_lane_enables_n,
	input  wire logic          host_rd_n,
	input  wire logic          host_wr_n,
	input  wire logic [31:0]   host_data_in,
	output logic [31:0]        host_data_out,
	output logic               host_data_oe_n,
	// device state in and out
	input  wire logic [15:0]   bus_error_flags,
	input  wire logic [15:0]   selftest_result,
	output logic [15:0]        chip_reset_ctrl,
	output logic [15:0]        bank_now,
	output logic               bus_is_16bit,
	output logic               load_busy,
	// eeprom
	input  wire logic          eeprom_load_enable_pin,
	output logic               ee_req,
	output logic [2:0]         ee_word,
	input  wire logic          ee_ack,
	input  wire logic [15:0]   ee_data
);
	import bior_pkg::*;

	typedef struct packed {
		logic [15:0] bank0_base_address;
		logic [15:0] bank0_rx_flow_watermark;
		logic [15:0] bank0_burst_length;
		logic [15:0] bank2_station_addr_low;
		logic [15:0] bank2_station_addr_mid;
		logic [15:0] bank2_station_addr_high;
		logic [15:0] bank3_internal_bus_word;
		logic [15:0] bank3_chip_reset;
		logic [15:0] bank3_bus_setup;
		logic [15:0] bank_selector;
		logic        bus_16bit;
		logic        wr_prev;
		logic [31:0] rdata;
		logic        oe_n;
		logic        busy;
	} bior_regs_t;

	bior_regs_t r;
	bior_regs_t next_r;
	bior_load_if ld ();

	bior_eeprom_load u_load (
		.clk                    (clk),
		.reset_n                (reset_n),
		.eeprom_load_enable_pin (eeprom_load_enable_pin),
		.ee_req                 (ee_req),
		.ee_word                (ee_word),
		.ee_ack                 (ee_ack),
		.ee_data                (ee_data),
		.ld                     (ld.loader)
	);

	// merge enabled bytes of a 16-bit word; en is active high
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
	                                        input logic [1:0] en);
		merge16 = {en[1] ? wd[15:8] : old[15:8], en[0] ? wd[7:0] : old[7:0]};
	endfunction

	// read lanes that are off come back as zero bytes
	function automatic logic [15:0] mask16(input logic [15:0] v, input logic [1:0] en);
		mask16 = {en[1] ? v[15:8] : 8'h00, en[0] ? v[7:0] : 8'h00};
	endfunction

	// word at byte offset off of the selected bank; reserved reads zero
	function automatic logic [15:0] read16(input bior_regs_t q, input logic [3:0] off,
	                                       input logic [15:0] ef, input logic [15:0] st);
		read16 = 16'h0000;
		if (off == off_bank_select) begin
			read16 = q.bank_selector;
		end else if (q.bank_selector == bank_host_cfg) begin
			case (off)
				off_word0: read16 = q.bank0_base_address;
				off_word4: read16 = q.bank0_rx_flow_watermark;
				// bus error is read live, never latched
				off_word6: read16 = ef;
				off_word8: read16 = q.bank0_burst_length;
				default:   read16 = 16'h0000;
			endcase
		end else if (q.bank_selector == bank_station) begin
			case (off)
				off_word0: read16 = q.bank2_station_addr_low;
				off_word2: read16 = q.bank2_station_addr_mid;
				off_word4: read16 = q.bank2_station_addr_high;
				default:   read16 = 16'h0000;
			endcase
		end else if (q.bank_selector == bank_internal) begin
			case (off)
				off_word0: read16 = q.bank3_internal_bus_word;
				off_word4: read16 = st;
				off_word6: read16 = q.bank3_chip_reset;
				off_word8: read16 = q.bank3_bus_setup;
				default:   read16 = 16'h0000;
			endcase
		end
	endfunction

	logic [3:0] lane_en;
	logic [3:0] off_lo;
	logic [3:0] off_hi;
	logic       wr_start;

	assign lane_en  = ~byte_lane_enables_n;
	// address bits 1:0 are ignored; the lanes pick the bytes
	// dword aligned: lanes 1:0 hit the low word, lanes 3:2 the high word
	assign off_lo   = {host_addr[3:2], 2'b00};
	assign off_hi   = {host_addr[3:2], 2'b10};
	// one write per strobe, taken on its falling edge
	assign wr_start = !host_wr_n && r.wr_prev;

	always_comb begin
		logic [15:0] wl;
		logic [15:0] wh;
		logic [1:0]  el;
		logic [1:0]  eh;
		logic [15:0] rlo;
		logic [15:0] rhi;
		wl = host_data_in[15:0];
		wh = host_data_in[31:16];
		el = lane_en[1:0];
		eh = lane_en[3:2];
		rlo = read16(r, off_lo, bus_error_flags, selftest_result);
		rhi = read16(r, off_hi, bus_error_flags, selftest_result);
		next_r = r;
		next_r.wr_prev = host_wr_n;
		next_r.busy = ld.busy;
		// read data held while strobe low; disabled lanes drive zero
		next_r.oe_n = host_rd_n;
		next_r.rdata = 32'h0000_0000;
		if (!host_rd_n) begin
			next_r.rdata[15:0]  = mask16(rlo, el);
			next_r.rdata[31:16] = mask16(rhi, eh);
		end
		// host writes use the bank held before this access; the new bank takes the next one
		// writes during loading are dropped, not queued
		if (wr_start && !ld.busy) begin
			if (off_hi == off_bank_select) begin
				next_r.bank_selector = merge16(r.bank_selector, wh, eh);
			end
			if (r.bank_selector == bank_host_cfg) begin
				case (host_addr[3:2])
					2'h0: next_r.bank0_base_address = merge16(r.bank0_base_address, wl, el);
					2'h1: next_r.bank0_rx_flow_watermark = merge16(r.bank0_rx_flow_watermark, wl, el);
					2'h2: next_r.bank0_burst_length = merge16(r.bank0_burst_length, wl, el);
					default: ;
				endcase
			end else if (r.bank_selector == bank_station) begin
				case (host_addr[3:2])
					// a 32-bit write fills low and mid words in one strobe
					2'h0: begin
						next_r.bank2_station_addr_low = merge16(r.bank2_station_addr_low, wl, el);
						next_r.bank2_station_addr_mid = merge16(r.bank2_station_addr_mid, wh, eh);
					end
					2'h1: next_r.bank2_station_addr_high = merge16(r.bank2_station_addr_high, wl, el);
					default: ;
				endcase
			end else if (r.bank_selector == bank_internal) begin
				case (host_addr[3:2])
					2'h0: next_r.bank3_internal_bus_word = merge16(r.bank3_internal_bus_word, wl, el);
					2'h1: next_r.bank3_chip_reset = merge16(r.bank3_chip_reset, wh, eh);
					2'h2: next_r.bank3_bus_setup = merge16(r.bank3_bus_setup, wl, el);
					default: ;
				endcase
			end
		end
		// start-up image overrides; host writes are held off until it ends
		if (ld.valid) begin
			case (ld.index)
				ee_base_word:   next_r.bank0_base_address = ld.data;
				ee_mac_lo_word: next_r.bank2_station_addr_low = ld.data;
				ee_mac_mi_word: next_r.bank2_station_addr_mid = ld.data;
				ee_mac_hi_word: next_r.bank2_station_addr_high = ld.data;
				ee_cfg_word:    next_r.bus_16bit = ld.data[ee_width_bit];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '{
				bank0_base_address:      rst_word,
				bank0_rx_flow_watermark: rst_word,
				bank0_burst_length:      rst_word,
				bank2_station_addr_low:  rst_word,
				bank2_station_addr_mid:  rst_word,
				bank2_station_addr_high: rst_word,
				bank3_internal_bus_word: rst_word,
				bank3_chip_reset:        rst_word,
				bank3_bus_setup:         rst_word,
				bank_selector:           rst_word,
				bus_16bit:               rst_bus_16bit,
				// writes arm only after a high strobe, so reset counts as high
				wr_prev:                 1'b1,
				rdata:                   32'h0000_0000,
				oe_n:                    1'b1,
				busy:                    1'b1
			};
		end else begin
			r <= next_r;
		end
	end

	// every output below is a plain flop of the state
	assign host_data_out   = r.rdata;
	assign host_data_oe_n  = r.oe_n;
	assign chip_reset_ctrl = r.bank3_chip_reset;
	assign bank_now        = r.bank_selector;
	assign bus_is_16bit    = r.bus_16bit;
	assign load_busy       = r.busy;
endmodule
`default_nettype wire

// [tb/bior_top_assertions.sv]
// concurrent checks on the register window ports
`timescale 1ns/1ps
`default_nettype none
module bior_top_assertions (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	// host bus
	input wire logic [3:0]  host_addr,
	input wire logic [3:0]  byte_lane_enables_n,
	input wire logic        host_rd_n,
	input wire logic        host_wr_n,
	input wire logic [31:0] host_data_in,
	input wire logic [31:0] host_data_out,
	input wire logic        host_data_oe_n,
	// device state and loader
	input wire logic [15:0] selftest_result,
	input wire logic [15:0] bank_now,
	input wire logic        load_busy,
	input wire logic        ee_req,
	input wire logic [2:0]  ee_word,
	input wire logic        ee_ack
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence rd_s(logic [1:0] dw);
		!host_rd_n && host_addr[3:2] == dw;
	endsequence
	// load_busy lags the loader, so low here means writes are honoured
	sequence bank_wr_s;
		$fell(host_wr_n) && !load_busy && host_addr[3:2] == 2'h3 && byte_lane_enables_n[3:2] == 2'b00;
	endsequence
	a_oe_tracks_rd: assert property (!host_rd_n |=> !host_data_oe_n) else $error("oe not on in read");
	a_idle_data_zero: assert property (host_rd_n |=> host_data_out == 32'h0) else $error("idle data");
	a_bank_sel_write: assert property (bank_wr_s |=> bank_now == $past(host_data_in[31:16]))
		else $error("bank write lost");
	a_bank_sel_read: assert property (rd_s(2'h3) and byte_lane_enables_n[3:2] == 2'b00
		|=> host_data_out[31:16] == $past(bank_now)) else $error("bank read");
	a_lane_off_zero: assert property (!host_rd_n && byte_lane_enables_n[0]
		|=> host_data_out[7:0] == 8'h0) else $error("disabled lane data");
	a_selftest_live: assert property (rd_s(2'h1) and bank_now == 16'h3 && byte_lane_enables_n[1:0] == 2'b00
		|=> host_data_out[15:0] == $past(selftest_result)) else $error("selftest read");
	a_reserved_zero: assert property (!host_rd_n && (bank_now == 16'h1 || bank_now > 16'h3)
		&& host_addr[3:2] != 2'h3 |=> host_data_out == 32'h0) else $error("reserved read");
	a_ee_step: assert property (ee_req && ee_ack |=> !ee_req || ee_word == $past(ee_word) + 3'h1)
		else $error("eeprom word order");
endmodule
`default_nettype wire

// [tb/bior_eeprom_model.sv]
// eeprom word source answering the loader
`timescale 1ns/1ps
`default_nettype none
module bior_eeprom_model (
	// clock and reset
	input wire logic         clk,
	input wire logic         reset_n,
	// word port
	input wire logic         ee_req,
	input wire logic [2:0]   ee_word,
	output logic             ee_ack,
	output logic [15:0]      ee_data
);
	logic [1:0] cnt;
	// word w holds w+8 in each nibble: word 0 differs from reset, word 6 picks 8-bit width
	wire logic [15:0] img = {4{1'b1, ee_word}};
	// stale data inverted so a late sample is caught
	assign ee_data = ee_ack ? img : ~img;
	// latency 3 or 4 cycles by word, never inside the dead cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ee_ack <= 1'b0;
			cnt    <= 2'h0;
		end else if (!ee_req || ee_ack) begin
			ee_ack <= 1'b0;
			cnt    <= 2'h0;
		end else if (cnt == {1'b1, ee_word[0]}) begin
			ee_ack <= 1'b1;
		end else begin
			cnt <= cnt + 2'h1;
		end
	end
endmodule
`default_nettype wire

// [tb/banked_io_register_window_bench.sv]
// self-checking bench for the banked register window
`timescale 1ns/1ps
`default_nettype none
module banked_io_register_window_bench;
	import bior_pkg::*;
	logic        clk = 0, reset_n = 0, rd_n = 1, wr_n = 1, ee_en = 1, ack, oe_n, b16, busy, req;
	logic [2:0]  wd;
	logic [3:0]  addr = 0, ben = 4'hf;
	logic [15:0] flags = 0, st = 0, ed, chip, bank, exp_bl = 0;
	logic [31:0] din = 0, dout, rd, seed = 32'h0c9c54fd;
	int          errors = 0, num_checks = 0, cyc = 0;
	always #50 clk = ~clk;
	bior_top i_dut (.clk(clk), .reset_n(reset_n), .host_addr(addr), .byte_lane_enables_n(ben),
		.host_rd_n(rd_n), .host_wr_n(wr_n), .host_data_in(din), .host_data_out(dout),
		.host_data_oe_n(oe_n), .bus_error_flags(flags), .selftest_result(st), .chip_reset_ctrl(chip),
		.bank_now(bank), .bus_is_16bit(b16), .load_busy(busy), .eeprom_load_enable_pin(ee_en),
		.ee_req(req), .ee_word(wd), .ee_ack(ack), .ee_data(ed));
	bior_eeprom_model i_ee (.clk(clk), .reset_n(reset_n), .ee_req(req), .ee_word(wd), .ee_ack(ack),
		.ee_data(ed));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] merge(input logic [15:0] o, n, input logic [1:0] en_n);
		return {en_n[1] ? o[15:8] : n[15:8], en_n[0] ? o[7:0] : n[7:0]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// strobe held two edges, then two edges high before the next one
	task automatic wr(input logic [3:0] a, b, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		ben  <= b;
		din  <= d;
		wr_n <= 1'b0;
		repeat (2) @(posedge clk);
		wr_n <= 1'b1;
		ben  <= 4'hf;
		@(posedge clk);
	endtask
	task automatic rdt(input logic [3:0] a, b);
		@(posedge clk);
		addr <= a;
		ben  <= b;
		rd_n <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		rd = dout;
		chk("host_data_oe_n", 32'h0, {31'h0, oe_n});
		@(posedge clk);
		rd_n <= 1'b1;
		ben  <= 4'hf;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			conclude();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk);
		chk("load_busy", 32'h0, {31'h0, busy});
		chk("bus_is_16bit", 32'h0, {31'h0, b16});
		// bank 0 after reset: base word comes from eeprom word 0
		rdt(off_word0, 4'hc);
		chk("base address", 32'h8888, rd);
		wr(off_bank_select, 4'h3, {bank_station, 16'h0});
		chk("bank_now", 32'h2, {16'h0, bank});
		rdt(off_word0, 4'h0);
		chk("station lo mid", 32'haaaa9999, rd);
		rdt(off_word4, 4'hc);
		chk("station hi", 32'hbbbb, rd);
		// bank 9 is all reserved except the selector word
		wr(off_bank_select, 4'h3, 32'h00090000);
		wr(off_word8, 4'h0, seed);
		rdt(off_word8, 4'h0);
		chk("reserved", 32'h0, rd);
		rdt(4'hc, 4'h0);
		chk("selector", 32'h00090000, rd);
		wr(off_bank_select, 4'h3, {bank_internal, 16'h0});
		wr(off_word4, 4'h0, {seed[31:16], ~seed[15:0]});
		chk("chip_reset_ctrl", {16'h0, seed[31:16]}, {16'h0, chip});
		@(posedge clk);
		st <= seed[15:0];
		rdt(off_word4, 4'h0);
		chk("selftest", {seed[31:16], seed[15:0]}, rd);
		wr(off_bank_select, 4'h3, {bank_host_cfg, 16'h0});
		// random lanes on burst length, readback through random lanes
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			wr(off_word8, seed[3:0], seed);
			exp_bl = merge(exp_bl, seed[15:0], seed[1:0]);
			rdt(off_word8, seed[7:4]);
			chk("burst", {16'h0, exp_bl} & {{8{~seed[7]}}, {8{~seed[6]}}, {8{~seed[5]}}, {8{~seed[4]}}}, rd);
		end
		// bus error word is read-only and live beside the watermark
		@(posedge clk);
		flags <= seed[31:16];
		wr(off_word4, 4'h0, {~seed[31:16], seed[15:0]});
		rdt(off_word4, 4'h0);
		chk("watermark bus error", seed, rd);
		// second reset in mid-run with the strap low: nothing is loaded
		@(posedge clk);
		reset_n <= 1'b0;
		ee_en   <= 1'b0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 20 && busy !== 1'b0; i++) @(posedge clk);
		chk("load_busy strap low", 32'h0, {31'h0, busy});
		chk("ee_req strap low", 32'h0, {31'h0, req});
		chk("bus_is_16bit default", 32'h1, {31'h0, b16});
		chk("bank after reset", 32'h0, {16'h0, bank});
		rdt(off_word0, 4'hc);
		chk("base not loaded", 32'h0, rd);
		wr(off_bank_select, 4'h3, {bank_station, 16'h0});
		rdt(off_word0, 4'h0);
		chk("station not loaded", 32'h0, rd);
		conclude();
	end
endmodule
bind bior_top bior_top_assertions i_chk (.clk, .reset_n, .host_addr, .byte_lane_enables_n, .host_rd_n,
	.host_wr_n, .host_data_in, .host_data_out, .host_data_oe_n, .selftest_result, .bank_now, .load_busy,
	.ee_req, .ee_word, .ee_ack);
`default_nettype wire
